// [src/phyvc_pkg.sv]
package phyvc_pkg;
    localparam logic [4:0]  REG_NP_PARTNER = 5'h08;
    localparam logic [4:0]  REG_DIG_POWER  = 5'h10;
    localparam logic [4:0]  REG_AFE_CTRL   = 5'h11;
    localparam logic [4:0]  REG_SYM_ERR    = 5'h15;
    localparam logic [4:0]  REG_STRAP_OVR  = 5'h16;
    localparam logic [4:0]  REG_EXP_CTRL   = 5'h18;
    localparam int          BIT_TOGGLE     = 11;
    localparam int          BIT_PLL_AUTO   = 4;
    localparam int          BIT_SLOW_OSC   = 5;
    localparam int          BIT_FACTORY    = 15;
    localparam int          BIT_BCAST_OFF  = 9;
    localparam int          BIT_RO_RSVD    = 10;
    localparam int          BIT_ENERGY_DETECT_POWER_DOWN_DIS   = 11;
    localparam logic [15:0] RST_DIG_POWER  = 16'h0000;
    localparam logic [15:0] RST_AFE_CTRL   = 16'h0000;
    localparam logic [15:0] RST_STRAP_OVR  = 16'h0002;
    localparam logic [15:0] RST_EXP_CTRL   = 16'h0800;
    localparam logic [15:0] RST_SYM_ERR    = 16'h0000;
    localparam logic [5:0]  PREAMBLE_LEN   = 6'h20;
    localparam logic [3:0]  HDR_BITS       = 4'hD;
    localparam logic [1:0]  OP_READ        = 2'h2;
    localparam logic [1:0]  OP_WRITE       = 2'h1;
    localparam logic [1:0]  STRAP_WAIT     = 2'h3;

    typedef struct packed {
        logic        valid;
        logic        tx_toggle;
        logic [10:0] message;
    } phyvc_np_t;

    typedef enum logic [1:0] {
        S_PRE,
        S_HDR,
        S_TURN,
        S_DATA
    } phyvc_state_t;
endpackage

// [src/phyvc_regs.sv]
`timescale 1ns/1ns
// Contract
// - Partner toggle reads 1 when our previous transmitted toggle was 0.
// - Partner message is an 11-bit read-only field reading zero after reset.
// - With PLL auto-shutdown set, the PLL is off during energy-detect sleep.
// - With PLL auto-shutdown clear (reset), the PLL keeps running.
// - Slow-oscillator enable swaps the reference input for the slow one.
// - While slow-oscillator enable is set the analog front end powers down.
// - A 16-bit symbol-error frame count clears on read and resets to zero.
// - Factory mode bit 1 selects factory test mode, 0 normal operation.
// - The factory mode bit loads the receive-error pin strap after reset.
// - Writing 0 to a latched factory mode bit leaves factory test mode.
// - Broadcast-disable bit makes address 0 non-broadcast; it resets to 0.
// - Energy-detect power-down works only while its disable bit is 0.
module phyvc_regs #(
    parameter logic [4:0] PHY_ADDR = 5'h03
) (
    // Clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              RST_N,
    // Management pins
    input  wire logic              MDC,
    input  wire logic              MDIO_IN,
    output logic                   MDIO_OUT,
    output logic                   MDIO_OE,
    // Strap pin
    input  wire logic              RX_ERR_STRAP,
    // Core events
    input  phyvc_pkg::phyvc_np_t   NP_RX,
    input  wire logic              SYM_ERR_FRAME,
    input  wire logic              NO_ENERGY,
    // Core controls
    output logic                   PLL_OFF,
    output logic                   SLOW_OSC_SEL,
    output logic                   AFE_POWER_DOWN,
    output logic                   FACTORY_TEST,
    output logic                   ENERGY_DETECT_POWER_DOWN_ENABLE
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] mdc_s;
    logic [1:0] mdio_s;
    logic [1:0] strap_s;
    logic       mdc_rise;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mdc_s   <= 3'h0;
            mdio_s  <= 2'h0;
            strap_s <= 2'h0;
        end else begin
            mdc_s   <= {mdc_s[1:0], MDC};
            mdio_s  <= {mdio_s[0], MDIO_IN};
            strap_s <= {strap_s[0], RX_ERR_STRAP};
        end
    end

    assign mdc_rise = mdc_s[1] & ~mdc_s[2];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic        np_toggle;
    logic [10:0] np_message;
    logic [15:0] dig_power;
    logic [15:0] afe_ctrl;
    logic [15:0] strap_ovr;
    logic [15:0] exp_ctrl;
    logic [15:0] sym_err;
    logic [1:0]  strap_cnt;
    logic        wr_en;
    logic        rd_clr;
    logic [4:0]  reg_addr;
    logic [15:0] wr_data;

    function automatic logic [15:0] read_reg(input logic [4:0] a);
        case (a)
            phyvc_pkg::REG_NP_PARTNER:
                read_reg = {4'h0, np_toggle, np_message};
            phyvc_pkg::REG_DIG_POWER: read_reg = dig_power;
            phyvc_pkg::REG_AFE_CTRL:  read_reg = afe_ctrl;
            phyvc_pkg::REG_SYM_ERR:   read_reg = sym_err;
            phyvc_pkg::REG_STRAP_OVR: read_reg = strap_ovr;
            phyvc_pkg::REG_EXP_CTRL:  read_reg = exp_ctrl;
            default:                  read_reg = 16'h0000;
        endcase
    endfunction

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            np_toggle  <= 1'b0;
            np_message <= 11'h000;
        end else if (NP_RX.valid) begin
            np_toggle  <= ~NP_RX.tx_toggle;
            np_message <= NP_RX.message;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dig_power <= phyvc_pkg::RST_DIG_POWER;
            afe_ctrl  <= phyvc_pkg::RST_AFE_CTRL;
            exp_ctrl  <= phyvc_pkg::RST_EXP_CTRL;
        end else if (wr_en) begin
            if (reg_addr == phyvc_pkg::REG_DIG_POWER)
                dig_power <= wr_data;
            if (reg_addr == phyvc_pkg::REG_AFE_CTRL)
                afe_ctrl <= wr_data;
            if (reg_addr == phyvc_pkg::REG_EXP_CTRL)
                exp_ctrl <= wr_data;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_ovr <= phyvc_pkg::RST_STRAP_OVR;
            strap_cnt <= 2'h0;
        end else begin
            if (strap_cnt != phyvc_pkg::STRAP_WAIT)
                strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == phyvc_pkg::STRAP_WAIT - 2'h1)
                strap_ovr[phyvc_pkg::BIT_FACTORY] <= strap_s[1];
            else if (wr_en && reg_addr == phyvc_pkg::REG_STRAP_OVR) begin
                strap_ovr <= wr_data;
                strap_ovr[phyvc_pkg::BIT_RO_RSVD] <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N)
            sym_err <= phyvc_pkg::RST_SYM_ERR;
        else if (rd_clr)
            sym_err <= {15'h0000, SYM_ERR_FRAME};
        else if (SYM_ERR_FRAME && sym_err != 16'hFFFF)
            sym_err <= sym_err + 16'h0001;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PLL_OFF        <= 1'b0;
            SLOW_OSC_SEL   <= 1'b0;
            AFE_POWER_DOWN <= 1'b0;
            FACTORY_TEST   <= 1'b0;
            ENERGY_DETECT_POWER_DOWN_ENABLE    <= 1'b0;
        end else begin
            ENERGY_DETECT_POWER_DOWN_ENABLE    <= ~exp_ctrl[phyvc_pkg::BIT_ENERGY_DETECT_POWER_DOWN_DIS];
            PLL_OFF        <= ~exp_ctrl[phyvc_pkg::BIT_ENERGY_DETECT_POWER_DOWN_DIS] & NO_ENERGY
                & dig_power[phyvc_pkg::BIT_PLL_AUTO];
            SLOW_OSC_SEL   <= afe_ctrl[phyvc_pkg::BIT_SLOW_OSC];
            AFE_POWER_DOWN <= afe_ctrl[phyvc_pkg::BIT_SLOW_OSC];
            FACTORY_TEST   <= strap_ovr[phyvc_pkg::BIT_FACTORY];
        end
    end

    // ------------------------------------------------------------
    // Management frame engine
    // ------------------------------------------------------------
    phyvc_pkg::phyvc_state_t state;
    logic [5:0]  pre_cnt;
    logic [3:0]  cnt;
    logic [12:0] hdr;
    logic [15:0] shift;
    logic        is_read;
    logic        hit;
    logic [4:0]  frame_phy;

    assign frame_phy = hdr[9:5];
    assign hit = (frame_phy == PHY_ADDR) || (frame_phy == 5'h00
        && !strap_ovr[phyvc_pkg::BIT_BCAST_OFF]);

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state    <= phyvc_pkg::S_PRE;
            pre_cnt  <= 6'h00;
            cnt      <= 4'h0;
            hdr      <= 13'h0000;
            shift    <= 16'h0000;
            is_read  <= 1'b0;
            reg_addr <= 5'h00;
            wr_data  <= 16'h0000;
            wr_en    <= 1'b0;
            rd_clr   <= 1'b0;
            MDIO_OUT <= 1'b0;
            MDIO_OE  <= 1'b0;
        end else begin
            wr_en  <= 1'b0;
            rd_clr <= 1'b0;
            if (mdc_rise) begin
                case (state)
                    phyvc_pkg::S_PRE: begin
                        if (mdio_s[1]) begin
                            if (pre_cnt != phyvc_pkg::PREAMBLE_LEN)
                                pre_cnt <= pre_cnt + 6'h01;
                        end else begin
                            if (pre_cnt == phyvc_pkg::PREAMBLE_LEN) begin
                                state <= phyvc_pkg::S_HDR;
                                cnt   <= 4'h0;
                            end
                            pre_cnt <= 6'h00;
                        end
                    end
                    phyvc_pkg::S_HDR: begin
                        hdr <= {hdr[11:0], mdio_s[1]};
                        cnt <= cnt + 4'h1;
                        if (cnt == phyvc_pkg::HDR_BITS - 4'h1) begin
                            state <= phyvc_pkg::S_TURN;
                            cnt   <= 4'h0;
                        end
                    end
                    phyvc_pkg::S_TURN: begin
                        cnt <= 4'h1;
                        if (cnt == 4'h0) begin
                            is_read  <= hit && hdr[11:10] == phyvc_pkg::OP_READ
                                && hdr[12];
                            reg_addr <= hdr[4:0];
                            shift    <= read_reg(hdr[4:0]);
                            if (hit && hdr[12]
                                && hdr[11:10] == phyvc_pkg::OP_READ) begin
                                MDIO_OE <= 1'b1;
                                rd_clr  <= hdr[4:0] == phyvc_pkg::REG_SYM_ERR;
                            end else if (!(hit && hdr[12] && hdr[11:10]
                                == phyvc_pkg::OP_WRITE))
                                state <= phyvc_pkg::S_PRE;
                        end else begin
                            state    <= phyvc_pkg::S_DATA;
                            cnt      <= 4'h0;
                            MDIO_OUT <= shift[15];
                            shift    <= {shift[14:0], 1'b0};
                        end
                    end
                    phyvc_pkg::S_DATA: begin
                        cnt      <= cnt + 4'h1;
                        MDIO_OUT <= shift[15];
                        shift    <= {shift[14:0], mdio_s[1]};
                        if (cnt == 4'hF) begin
                            state    <= phyvc_pkg::S_PRE;
                            MDIO_OE  <= 1'b0;
                            MDIO_OUT <= 1'b0;
                            wr_data  <= {shift[14:0], mdio_s[1]};
                            wr_en    <= !is_read;
                        end
                    end
                    default: state <= phyvc_pkg::S_PRE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_toggle_inverts: assert property (NP_RX.valid |=>
        np_toggle == !$past(NP_RX.tx_toggle))
        else $error("partner toggle not inverted");
    a_message_capture: assert property (NP_RX.valid |=>
        np_message == $past(NP_RX.message))
        else $error("partner message not captured");
    a_pll_auto_off: assert property (dig_power[4] && NO_ENERGY
        && !exp_ctrl[11] |=> PLL_OFF)
        else $error("pll not shut off");
    a_pll_kept_on: assert property (!dig_power[4] |=> !PLL_OFF)
        else $error("pll shut off without enable");
    a_slow_osc_afe: assert property (##1 SLOW_OSC_SEL
        == $past(afe_ctrl[5]) && AFE_POWER_DOWN == SLOW_OSC_SEL)
        else $error("afe power-down not tied to slow oscillator");
    a_count_clear: assert property (rd_clr && !SYM_ERR_FRAME |=>
        sym_err == 16'h0000)
        else $error("count not cleared by read");
    a_count_step: assert property (!rd_clr && SYM_ERR_FRAME
        && sym_err != 16'hFFFF |=> sym_err == $past(sym_err) + 16'h0001)
        else $error("count did not advance");
    a_factory_follow: assert property (##1 FACTORY_TEST
        == $past(strap_ovr[15]))
        else $error("factory mode output mismatch");
    a_strap_load: assert property (strap_cnt == 2'h2 |=>
        strap_ovr[15] == $past(strap_s[1]))
        else $error("strap not loaded");
    a_energy_detect_power_down_gate: assert property (exp_ctrl[11] |=>
        !ENERGY_DETECT_POWER_DOWN_ENABLE && !PLL_OFF)
        else $error("energy_detect_power_down active while disabled");
    a_ro_reserved: assert property (!strap_ovr[10])
        else $error("read-only reserved bit set");
    a_bcast_off: assert property ($rose(MDIO_OE) |->
        frame_phy == PHY_ADDR || frame_phy == 5'h00 && !strap_ovr[9])
        else $error("broadcast address accepted while disabled");

    c_read_frame: cover property (@(posedge SYS_CLK) rd_clr);
    c_write_frame: cover property (@(posedge SYS_CLK) wr_en);
    c_pll_off: cover property (@(posedge SYS_CLK) PLL_OFF);
endmodule

// [tb/phyvc_mdio_master.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Management controller that drives frames on the serial bus.
// ----------------------------------------------------------------
module phyvc_mdio_master (
    // Clock
    input  wire logic        clk,
    // Management pins
    input  wire logic        mdio_in,
    output logic             mdc,
    output logic             mdio_out,
    output logic             mdio_oe,
    // Read result
    output logic [15:0]      rd_data,
    output logic             rd_done
);
    initial begin
        mdc = 1'b0;
        mdio_out = 1'b1;
        mdio_oe = 1'b0;
        rd_data = 16'h0000;
        rd_done = 1'b0;
    end

    // One frame with a fresh preamble; data bits change while the clock is
    // low and read bits are taken just before the next rising edge.
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] ra, input logic [15:0] wd);
        logic [63:0] bits;
        logic [15:0] rd;
        bits = {32'hFFFF_FFFF, 2'b01, op, phy, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            mdio_oe = !(op == phyvc_pkg::OP_READ && i >= 46);
            mdio_out = bits[63-i];
            repeat (6) @(negedge clk);
            if (i >= 48) begin
                rd = {rd[14:0], mdio_in};
            end
            mdc = 1'b1;
            repeat (6) @(negedge clk);
            mdc = 1'b0;
        end
        mdio_oe = 1'b0;
        repeat (8) @(negedge clk);
        if (op == phyvc_pkg::OP_READ) begin
            rd_data = rd;
            rd_done = 1'b1;
            @(negedge clk);
            rd_done = 1'b0;
        end
    endtask
endmodule

// [tb/tb_phyvc_regs.sv]
`timescale 1ns/1ns
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin \
    n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module tb_phyvc_regs;
    logic                 sys_clk, rst_n, strap, sym_err, no_energy;
    phyvc_pkg::phyvc_np_t np_rx;
    logic                 mdc, m_out, m_oe, d_out, d_oe, rd_done;
    logic                 pll_off, slow, afe_pd, factory, energy_detect_power_down_en;
    logic [15:0]          rd_data, d, e;
    logic [10:0]          msg;
    logic [15:0]          exp_q[$];
    wire                  mdio = d_oe ? d_out : (m_oe ? m_out : 1'b1);
    int                   n_mismatch = 0, n_compared = 0, n;

    phyvc_regs #(.PHY_ADDR(5'h03)) u_phyvc_regs (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .MDC(mdc), .MDIO_IN(mdio),
        .MDIO_OUT(d_out), .MDIO_OE(d_oe), .RX_ERR_STRAP(strap),
        .NP_RX(np_rx), .SYM_ERR_FRAME(sym_err), .NO_ENERGY(no_energy),
        .PLL_OFF(pll_off), .SLOW_OSC_SEL(slow), .AFE_POWER_DOWN(afe_pd),
        .FACTORY_TEST(factory), .ENERGY_DETECT_POWER_DOWN_ENABLE(energy_detect_power_down_en));
    phyvc_mdio_master u_phyvc_mdio_master (
        .clk(sys_clk), .mdio_in(mdio), .mdc(mdc), .mdio_out(m_out),
        .mdio_oe(m_oe), .rd_data(rd_data), .rd_done(rd_done));

    always #25 sys_clk = ~sys_clk;

    task automatic tally_and_finish();
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic rd(input logic [4:0] p, input logic [4:0] a,
                      input logic [15:0] x);
        exp_q.push_back(x);
        u_phyvc_mdio_master.frame(phyvc_pkg::OP_READ, p, a, 16'h0000);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] x);
        u_phyvc_mdio_master.frame(phyvc_pkg::OP_WRITE, 5'h03, a, x);
    endtask

    // ----------------------------------------------------------------
    // Result watcher.
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rd_done === 1'b1) begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hXXXX;
            `CHK(rd_data, e)
        end
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        strap = 1'b1;
        sym_err = 1'b0;
        no_energy = 1'b0;
        np_rx = '0;
        void'($urandom(74));
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        rd(5'h03, phyvc_pkg::REG_STRAP_OVR, 16'h8002);
        `CHK(factory, 1'b1)
        wr(phyvc_pkg::REG_STRAP_OVR, 16'h0600);
        rd(5'h03, phyvc_pkg::REG_STRAP_OVR, 16'h0200);
        `CHK(factory, 1'b0)
        rd(5'h00, phyvc_pkg::REG_STRAP_OVR, 16'hFFFF);
        wr(phyvc_pkg::REG_STRAP_OVR, 16'h0000);
        rd(5'h00, phyvc_pkg::REG_STRAP_OVR, 16'h0000);
        rd(5'h03, phyvc_pkg::REG_NP_PARTNER, 16'h0000);
        for (int t = 0; t < 2; t++) begin
            msg = 11'($urandom);
            np_rx = {1'b1, t[0], msg};
            @(negedge sys_clk);
            np_rx.valid = 1'b0;
            wr(phyvc_pkg::REG_NP_PARTNER, 16'hFFFF);
            rd(5'h03, phyvc_pkg::REG_NP_PARTNER, {4'h0, ~t[0], msg});
        end
        n = 1 + ($urandom % 20);
        repeat (n) begin
            sym_err = 1'b1;
            @(negedge sys_clk);
            sym_err = 1'b0;
            @(negedge sys_clk);
        end
        rd(5'h03, phyvc_pkg::REG_SYM_ERR, 16'(n));
        rd(5'h03, phyvc_pkg::REG_SYM_ERR, 16'h0000);
        no_energy = 1'b1;
        repeat (4) @(negedge sys_clk);
        `CHK(energy_detect_power_down_en, 1'b0)
        `CHK(pll_off, 1'b0)
        rd(5'h03, phyvc_pkg::REG_DIG_POWER, 16'h0000);
        wr(phyvc_pkg::REG_EXP_CTRL, 16'h0000);
        `CHK(energy_detect_power_down_en, 1'b1)
        `CHK(pll_off, 1'b0)
        d = 16'($urandom) | 16'h0010;
        wr(phyvc_pkg::REG_DIG_POWER, d);
        rd(5'h03, phyvc_pkg::REG_DIG_POWER, d);
        `CHK(pll_off, 1'b1)
        no_energy = 1'b0;
        repeat (4) @(negedge sys_clk);
        `CHK(pll_off, 1'b0)
        rd(5'h03, phyvc_pkg::REG_AFE_CTRL, 16'h0000);
        for (int v = 1; v >= 0; v--) begin
            wr(phyvc_pkg::REG_AFE_CTRL, 16'(v) << 5);
            `CHK(slow, v[0])
            `CHK(afe_pd, v[0])
        end
        rd(5'h03, 5'h1F, 16'h0000);
        strap = 1'b0;
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        rd(5'h03, phyvc_pkg::REG_STRAP_OVR, 16'h0002);
        `CHK(factory, 1'b0)
        `CHK(energy_detect_power_down_en, 1'b0)
        rd(5'h03, phyvc_pkg::REG_NP_PARTNER, 16'h0000);
        rd(5'h03, phyvc_pkg::REG_DIG_POWER, 16'h0000);
        `CHK(exp_q.size(), 0)
        tally_and_finish();
    end
endmodule
